// file: core/gpwe_pkg.sv
package gpwe_pkg;

  // ***************************************************
  // Sizes
  // ***************************************************
  localparam int NPINS = 32; // Pins in the port block
  localparam int NEETI = 6; // Either-edge capable pins

  // Per-pin configuration byte
  typedef struct packed {
    logic od; // 1 open drain, 0 push-pull
    logic [4:0] rsvd; // Reads as zero
    logic pol; // 1 inverted
    logic dir; // 1 input, 0 output
  } gpwe_cfg_t;

  // Alternate-function flavour of a pin
  typedef struct packed {
    logic joy; // Joystick axis
    logic ddc; // Drive density control
    logic either_edge_irq; // Either-edge interrupt
    logic kbc; // Keyboard controller port bit
    logic shint; // Group system interrupt output
  } gpwe_kind_t;

  // ***************************************************
  // Register offsets (byte addresses)
  // ***************************************************
  localparam logic [7:0] OFS_CFG_LAST = 8'h7C;
  localparam logic [7:0] OFS_DATA = 8'h80;
  localparam logic [7:0] OFS_WAKE_STS = 8'h84;
  localparam logic [7:0] OFS_WAKE_EN = 8'h88;
  localparam logic [7:0] OFS_WAKE_GEN = 8'h8C;
  localparam logic [7:0] OFS_SYS_STS = 8'h90;
  localparam logic [7:0] OFS_SYS_EN = 8'h94;
  localparam logic [7:0] OFS_MISC_STS = 8'h98;
  localparam logic [7:0] OFS_ALT_SEL = 8'h9C;
  localparam logic [7:0] OFS_GROUP_EN = 8'hA0;

  // ***************************************************
  // Reset values and field masks
  // ***************************************************
  localparam logic [7:0] CFG_RST_IN = 8'h01;
  localparam logic [7:0] CFG_RST_OUT = 8'h00;
  localparam logic [7:0] CFG_RD_MASK = 8'h83;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [31:0] ALT_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // ***************************************************
  // Pin capability maps
  // ***************************************************
  localparam logic [31:0] WAKE_CAP = 32'h7FFF_FFFF;
  localparam logic [31:0] SYSINT_CAP = 32'h07FF_FF00;
  localparam int FAN1_BIT = 30;
  localparam int FAN2_BIT = 31;
  localparam logic [31:0] EITHER_EDGE_IRQ_MASK = 32'h00CA_0600;
  localparam logic [31:0] JOY_MASK = 32'h0000_00F0;
  localparam logic [31:0] KBC_MASK = 32'h0011_0000;
  localparam logic [31:0] DDC_MASK = 32'h0020_0000;
  localparam logic [31:0] SHINT_MASK = 32'h0000_8000;
  localparam logic [31:0] OUT_LOW_RST = 32'h2000_3000;

endpackage : gpwe_pkg

// file: core/gpwe_pin_cell.sv
`timescale 1ns/1ps
module gpwe_pin_cell (
  input wire logic mclk,
  input wire logic rst_n,
  input wire gpwe_pkg::gpwe_cfg_t cfg,
  input wire gpwe_pkg::gpwe_kind_t kind,
  input wire logic data_bit,
  input wire logic alt_sel,
  input wire logic alt_o,
  input wire logic alt_oe,
  input wire logic group_val,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic alt_in,
  output logic level,
  output logic sense,
  output logic event_o,
  output logic any_edge
);

  // ***************************************************
  // Input synchroniser and edges
  // ***************************************************
  logic [1:0] sync_q; // Only sync_q[1] is looked at
  logic prev_q; // Last synced level
  logic rise; // Rising edge seen
  logic fall; // Falling edge seen
  logic either_edge_irq_sel; // Either-edge function active
  logic [1:0] drv; // {out, oe} before the flop

  // Two-flop sync then one history flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 2'h0;
      prev_q <= 1'h0;
    end else begin
      sync_q <= {sync_q[0], pin_i};
      prev_q <= sync_q[1];
    end
  end

  assign rise = sync_q[1] & ~prev_q;
  assign fall = ~sync_q[1] & prev_q;
  assign any_edge = rise | fall;
  assign either_edge_irq_sel = alt_sel & kind.either_edge_irq;
  // Either-edge ignores direction, so it always senses
  assign sense = cfg.dir | either_edge_irq_sel;
  // Data read view keeps polarity even for either-edge
  assign level = sync_q[1] ^ cfg.pol;

  // Edge choice; outputs raise no events unless either-edge is selected
  always_comb begin
    if (either_edge_irq_sel) begin
      event_o = rise | fall;
    end else if (cfg.dir) begin
      event_o = cfg.pol ? fall : rise;
    end else begin
      event_o = 1'b0;
    end
  end

  // ***************************************************
  // Pad drive
  // ***************************************************
  // Open drain only ever pulls low
  function automatic logic [1:0] drive(input logic v, input logic en, input logic od);
    if (!en) begin
      drive = 2'h0;
    end else if (od) begin
      drive = {1'b0, ~v};
    end else begin
      drive = {v, 1'b1};
    end
  endfunction : drive

  // Function select picks value, enable and buffer type
  always_comb begin
    drv = drive(data_bit ^ cfg.pol, ~cfg.dir, cfg.od);
    if (alt_sel) begin
      if (kind.either_edge_irq) begin
        drv = 2'h0;
      end else if (kind.joy) begin
        drv = drive(alt_o, alt_oe, 1'b1);
      end else if (kind.ddc) begin
        drv = drive(alt_o, alt_oe, cfg.od);
      end else if (kind.shint) begin
        drv = drive(~(group_val ^ cfg.pol), 1'b1, cfg.od);
      end else begin
        // Bidirectional alternates steer their own enable
        drv = drive(alt_o ^ cfg.pol, alt_oe, cfg.od);
      end
    end
  end

  // Registered pad outputs, glitch free
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
      alt_in <= 1'b0;
    end else begin
      pin_o <= drv[1];
      pin_oe <= drv[0];
      alt_in <= (kind.joy | kind.ddc | kind.either_edge_irq) ? sync_q[1] : level;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Sampled reset keeps the release edge out: the pad flops are still held there
  sequence s_gpio_pp_out;
    rst_n && !alt_sel && !cfg.dir && !cfg.od;
  endsequence

  AST_PP_OUT: assert property (s_gpio_pp_out |=>
    pin_oe && (pin_o == $past(data_bit ^ cfg.pol)))
    else $error("push-pull output does not follow data");
  AST_EITHER_EDGE_IRQ_FLOAT: assert property (either_edge_irq_sel |=> !pin_oe)
    else $error("either-edge pin is driven");
  AST_JOY_OD: assert property (alt_sel && kind.joy |=> !pin_o)
    else $error("joystick pin drives high");
  AST_OUT_SILENT: assert property (!cfg.dir && !either_edge_irq_sel |-> !event_o)
    else $error("output pin raised an event");

endmodule : gpwe_pin_cell

// file: core/gpwe_port.sv
`timescale 1ns/1ps
module gpwe_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] pin_i,
  output logic [31:0] pin_o,
  output logic [31:0] pin_oe,
  input wire logic [31:0] alt_out,
  input wire logic [31:0] alt_oe,
  output logic [31:0] alt_in,
  input wire logic fan_speed_sense_1,
  input wire logic fan_speed_sense_2,
  output logic wake_event,
  output logic internal_sysint
);

  // ***************************************************
  // Reset release
  // ***************************************************
  logic [1:0] rst_sq; // Release shift, asserts at once
  logic rst_sn; // Internal reset, active low
  // Assert asynchronously, release after two edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sq <= 2'h0;
    end else begin
      rst_sq <= {rst_sq[0], 1'b1};
    end
  end
  assign rst_sn = rst_sq[1];
  // ***************************************************
  // Register state
  // ***************************************************
  gpwe_pkg::gpwe_cfg_t cfg_q [gpwe_pkg::NPINS]; // Per-pin config
  logic [31:0] data_q; // Output data latch
  logic [31:0] wake_sts_q; // Wake status, sticky
  logic [31:0] wake_en_q; // Wake enables
  logic wake_gen_q; // Global wake enable
  logic [31:0] sys_sts_q; // System interrupt status
  logic [31:0] sys_en_q; // System interrupt enables
  logic [5:0] misc_sts_q; // Either-edge status
  logic [31:0] alt_sel_q; // Alternate function select
  logic group_en_q; // Route group interrupt to pin
  // Pin cell results
  logic [31:0] level; // Synced level, polarity applied
  logic [31:0] sense; // Pin currently sensing
  logic [31:0] event_v; // Selected-edge events
  logic [31:0] edge_v; // Any edge
  logic group_val; // Group interrupt level

  // ***************************************************
  // Bus slave
  // ***************************************************
  logic a_ph; // Valid address phase
  logic wr_pend_q; // Write data phase pending
  logic [7:0] wr_addr_q; // Latched write address
  logic [7:0] raddr; // Read address, word aligned
  logic [31:0] rd_word; // Read mux output
  logic [31:0] rd_data_v; // Data register read view
  assign a_ph = hsel && hready && htrans[1];
  assign raddr = {haddr[7:2], 2'h0};
  // Decode a pending write against one offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_pend_q && (wr_addr_q == ofs);
  endfunction : wr_hit
  // Latch write address; data follows next cycle
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= a_ph && hwrite;
      wr_addr_q <= raddr;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Data read mixes pin levels and stored bits
  always_comb begin
    for (int i = 0; i < gpwe_pkg::NPINS; i++) begin
      rd_data_v[i] = sense[i] ? level[i] : data_q[i];
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_word = gpwe_pkg::ZERO32;
    if (raddr <= gpwe_pkg::OFS_CFG_LAST) begin
      rd_word = {24'h00_0000, cfg_q[raddr[6:2]] & gpwe_pkg::CFG_RD_MASK};
    end else begin
      case (raddr)
        gpwe_pkg::OFS_DATA: rd_word = rd_data_v;
        gpwe_pkg::OFS_WAKE_STS: rd_word = wake_sts_q;
        gpwe_pkg::OFS_WAKE_EN: rd_word = wake_en_q;
        gpwe_pkg::OFS_WAKE_GEN: rd_word = {31'h0000_0000, wake_gen_q};
        gpwe_pkg::OFS_SYS_STS: rd_word = sys_sts_q;
        gpwe_pkg::OFS_SYS_EN: rd_word = sys_en_q;
        gpwe_pkg::OFS_MISC_STS: rd_word = {26'h000_0000, misc_sts_q};
        gpwe_pkg::OFS_ALT_SEL: rd_word = alt_sel_q;
        gpwe_pkg::OFS_GROUP_EN: rd_word = {31'h0000_0000, group_en_q};
        default: rd_word = gpwe_pkg::ZERO32;
      endcase
    end
  end

  // Pin level is captured at the read's address phase
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      hrdata <= gpwe_pkg::ZERO32;
    end else if (a_ph && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // ***************************************************
  // Configuration and data
  // ***************************************************
  for (genvar g = 0; g < gpwe_pkg::NPINS; g++) begin : g_cfg
    // Three pins wake up as low outputs
    always_ff @(posedge mclk or negedge rst_sn) begin
      if (!rst_sn) begin
        cfg_q[g] <= gpwe_pkg::OUT_LOW_RST[g] ? gpwe_pkg::CFG_RST_OUT
                                             : gpwe_pkg::CFG_RST_IN;
      end else if (wr_hit(8'(g * 4))) begin
        cfg_q[g] <= hwdata[7:0] & gpwe_pkg::CFG_RD_MASK;
      end
    end
  end

  // Only output bits take new data
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      data_q <= gpwe_pkg::DATA_RST;
    end else if (wr_hit(gpwe_pkg::OFS_DATA)) begin
      data_q <= (data_q & sense) | (hwdata & ~sense);
    end
  end

  // Alternate select; all pins start as plain GPIO
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      alt_sel_q <= gpwe_pkg::ALT_RST;
    end else if (wr_hit(gpwe_pkg::OFS_ALT_SEL)) begin
      alt_sel_q <= hwdata;
    end
  end

  // Enables; only capable bits exist
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      wake_en_q <= gpwe_pkg::ZERO32;
      sys_en_q <= gpwe_pkg::ZERO32;
      wake_gen_q <= 1'b0;
      group_en_q <= 1'b0;
    end else begin
      if (wr_hit(gpwe_pkg::OFS_WAKE_EN)) begin
        wake_en_q <= hwdata & gpwe_pkg::WAKE_CAP;
      end
      if (wr_hit(gpwe_pkg::OFS_SYS_EN)) begin
        sys_en_q <= hwdata & (gpwe_pkg::SYSINT_CAP | 32'hC000_0000);
      end
      if (wr_hit(gpwe_pkg::OFS_WAKE_GEN)) begin
        wake_gen_q <= hwdata[0];
      end
      if (wr_hit(gpwe_pkg::OFS_GROUP_EN)) begin
        group_en_q <= hwdata[0];
      end
    end
  end

  // ***************************************************
  // Pin cells
  // ***************************************************
  assign group_val = internal_sysint & group_en_q;
  for (genvar g = 0; g < gpwe_pkg::NPINS; g++) begin : g_pin
    gpwe_pkg::gpwe_kind_t kind;
    assign kind = '{joy: gpwe_pkg::JOY_MASK[g], ddc: gpwe_pkg::DDC_MASK[g],
                    either_edge_irq: gpwe_pkg::EITHER_EDGE_IRQ_MASK[g], kbc: gpwe_pkg::KBC_MASK[g],
                    shint: gpwe_pkg::SHINT_MASK[g]};
    gpwe_pin_cell u_cell (
      .mclk(mclk),
      .rst_n(rst_sn),
      .cfg(cfg_q[g]),
      .kind(kind),
      .data_bit(data_q[g]),
      .alt_sel(alt_sel_q[g]),
      .alt_o(alt_out[g]),
      .alt_oe(alt_oe[g]),
      .group_val(group_val),
      .pin_i(pin_i[g]),
      .pin_o(pin_o[g]),
      .pin_oe(pin_oe[g]),
      .alt_in(alt_in[g]),
      .level(level[g]),
      .sense(sense[g]),
      .event_o(event_v[g]),
      .any_edge(edge_v[g])
    );
  end

  // ***************************************************
  // Fan tachometer edges
  // ***************************************************
  logic [2:0] fan1_q; // Sync pair plus history
  logic [2:0] fan2_q; // Sync pair plus history
  logic [31:0] fan_set; // Fan rises at their status bits
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      fan1_q <= 3'h0;
      fan2_q <= 3'h0;
    end else begin
      fan1_q <= {fan1_q[1:0], fan_speed_sense_1};
      fan2_q <= {fan2_q[1:0], fan_speed_sense_2};
    end
  end

  always_comb begin
    fan_set = gpwe_pkg::ZERO32;
    fan_set[gpwe_pkg::FAN1_BIT] = fan1_q[1] & ~fan1_q[2];
    fan_set[gpwe_pkg::FAN2_BIT] = fan2_q[1] & ~fan2_q[2];
  end

  // ***************************************************
  // Sticky status
  // ***************************************************
  logic [31:0] wake_set; // New wake events
  logic [31:0] wake_clr; // Write-one clears
  logic [31:0] sys_set; // New interrupt events
  logic [31:0] sys_clr; // Write-one clears
  logic [5:0] misc_set; // New either-edge events
  logic [5:0] misc_clr; // Write-one clears
  // Set term sits outside the clear mask so a same-cycle event survives
  function automatic logic [31:0] w1c(input logic [31:0] q, input logic [31:0] s,
                                      input logic [31:0] c);
    w1c = s | (q & ~c);
  endfunction : w1c
  // Gather the six either-edge pins in pin order
  function automatic logic [5:0] pack_either_edge_irq(input logic [31:0] v);
    logic [5:0] r;
    int k;
    r = 6'h00;
    k = 0;
    for (int i = 0; i < gpwe_pkg::NPINS; i++) begin
      if (gpwe_pkg::EITHER_EDGE_IRQ_MASK[i]) begin
        r[k[2:0]] = v[i];
        k++;
      end
    end
    pack_either_edge_irq = r;
  endfunction : pack_either_edge_irq
  assign wake_set = event_v & gpwe_pkg::WAKE_CAP;
  assign sys_set = (event_v & gpwe_pkg::SYSINT_CAP) | fan_set;
  // Misc status records edges whatever the enables hold
  assign misc_set = pack_either_edge_irq(edge_v);
  assign wake_clr = wr_hit(gpwe_pkg::OFS_WAKE_STS) ? hwdata : gpwe_pkg::ZERO32;
  assign sys_clr = wr_hit(gpwe_pkg::OFS_SYS_STS) ? hwdata : gpwe_pkg::ZERO32;
  assign misc_clr = wr_hit(gpwe_pkg::OFS_MISC_STS) ? hwdata[5:0] : 6'h00;

  // Status update; zero bits of a write leave bits alone
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      wake_sts_q <= gpwe_pkg::ZERO32;
      sys_sts_q <= gpwe_pkg::ZERO32;
      misc_sts_q <= 6'h00;
    end else begin
      wake_sts_q <= w1c(wake_sts_q, wake_set, wake_clr);
      sys_sts_q <= w1c(sys_sts_q, sys_set, sys_clr);
      misc_sts_q <= 6'(w1c({26'h000_0000, misc_sts_q}, {26'h000_0000, misc_set},
                           {26'h000_0000, misc_clr}));
    end
  end

  // ***************************************************
  // Event outputs
  // ***************************************************
  // Registered so outputs stay glitch free
  always_ff @(posedge mclk or negedge rst_sn) begin
    if (!rst_sn) begin
      wake_event <= 1'b0;
      internal_sysint <= 1'b0;
    end else begin
      wake_event <= wake_gen_q && |(wake_sts_q & wake_en_q);
      internal_sysint <= |(sys_sts_q & sys_en_q);
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sn);
  sequence s_rd_data;
    a_ph && !hwrite && (raddr == gpwe_pkg::OFS_DATA);
  endsequence
  // Plain terms: a function body here would read unsampled values
  sequence s_wr_data;
    wr_pend_q && (wr_addr_q == gpwe_pkg::OFS_DATA);
  endsequence

  AST_RD_DATA: assert property (s_rd_data |=> hrdata == $past(rd_data_v))
    else $error("data read mismatch");
  AST_IN_WR: assert property (s_wr_data |=>
    (data_q & $past(sense)) == $past(data_q & sense))
    else $error("input data bit changed by write");
  AST_OUT_WR: assert property (s_wr_data |=>
    (data_q & ~$past(sense)) == $past(hwdata & ~sense))
    else $error("output data bit not written");
  AST_SET_WINS: assert property (1'b1 |=>
    (wake_sts_q & $past(wake_set)) == $past(wake_set))
    else $error("wake event lost");
  AST_W1C: assert property (wr_pend_q && (wr_addr_q == gpwe_pkg::OFS_WAKE_STS)
    && !(|wake_set) |=> (wake_sts_q & $past(hwdata)) == 32'h0000_0000)
    else $error("wake status not cleared");
  AST_WAKE_OUT: assert property (wake_gen_q && |(wake_sts_q & wake_en_q) |=>
    wake_event)
    else $error("wake event missing");
  AST_WAKE_GATE: assert property (!wake_gen_q |=> !wake_event)
    else $error("wake event without global enable");
  AST_NO_OUT_STS: assert property (1'b1 |=>
    ((wake_sts_q & ~$past(wake_sts_q)) & ~$past(sense)) == 32'h0000_0000)
    else $error("output pin set wake status");
  AST_READY: assert property (hreadyout && !hresp)
    else $error("slave not ready or error");

endmodule : gpwe_port

// file: test/gpwe_board.sv
`timescale 1ns/1ps
// ****************************************
// Board levels seen by the port pins
// ****************************************
module gpwe_board (
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_lvl,
  output logic [31:0] pin_i
);
  // A driven pin reads its own drive; a released pin sees the board level
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule : gpwe_board

// file: test/gpio_port_with_wake_events_tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Bench top: bus tasks and scenarios
// ****************************************
module gpio_port_with_wake_events_tb_top;
  logic mclk, rst_n, hsel, hwrite, hreadyout, hresp, wake_event, internal_sysint, fan1;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, pin_o, pin_oe, pin_i, ext_lvl, r, ai;
  int failures, samples_checked;
  // One slave, so its ready is the bus ready
  gpwe_port gpwe_port_inst (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .alt_out(32'h0000_0000), .alt_oe(32'h0000_0000), .alt_in(ai),
    .fan_speed_sense_1(fan1), .fan_speed_sense_2(1'b0), .wake_event(wake_event),
    .internal_sysint(internal_sysint));
  gpwe_board gpwe_board_inst (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));
  // Free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for ready sampled high at a rising edge
  task hwait;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask : hwait
  // Single word transfer; read data lands in r
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask : xfer
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(r & m, e);
  endtask : rdc
  // Board moves one pin, then the sync and edge stages settle
  task pin(input int k, input logic v);
    @(posedge mclk);
    ext_lvl[k] <= v;
    repeat (6) @(posedge mclk);
  endtask : pin
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ext_lvl = 32'h0000_0000;
    fan1 = 1'b0;
    failures = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(8'h00, 32'h0000_00FF, 32'h0000_0001);
    rdc(8'h30, 32'h0000_00FF, 32'h0000_0000);
    rdc(8'h54, 32'h0000_00FF, 32'h0000_0001);
    chk(pin_oe & 32'h2000_3000, 32'h2000_3000);
    chk(pin_o & 32'h2000_3000, 32'h0000_0000);
    $display("test reset done");
    // Pin 0 as push-pull output, then inverted, then open drain
    xfer(1'b1, 8'h00, 32'h0000_0000);
    xfer(1'b1, gpwe_pkg::OFS_DATA, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(pin_o & pin_oe & 32'h0000_0001, 32'h0000_0001);
    rdc(gpwe_pkg::OFS_DATA, 32'h0000_0001, 32'h0000_0001);
    xfer(1'b1, 8'h00, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk(pin_o & 32'h0000_0001, 32'h0000_0000);
    rdc(gpwe_pkg::OFS_DATA, 32'h0000_0001, 32'h0000_0001);
    xfer(1'b1, 8'h00, 32'h0000_0080);
    repeat (2) @(posedge mclk);
    chk(pin_oe & 32'h0000_0001, 32'h0000_0000);
    rdc(gpwe_pkg::OFS_WAKE_STS, 32'h0000_0001, 32'h0000_0000);
    $display("test output done");
    // Pin 1 input: read level, writes ignored, polarity applied
    pin(1, 1'b1);
    chk(ai & 32'h0000_0002, 32'h0000_0002);
    xfer(1'b1, gpwe_pkg::OFS_DATA, 32'h0000_0003);
    rdc(gpwe_pkg::OFS_DATA, 32'h0000_0002, 32'h0000_0002);
    xfer(1'b1, 8'h04, 32'h0000_0003);
    rdc(gpwe_pkg::OFS_DATA, 32'h0000_0002, 32'h0000_0000);
    chk(ai & 32'h0000_0002, 32'h0000_0000);
    // Pin 1 as output shows the latch that the ignored write left at zero
    xfer(1'b1, 8'h04, 32'h0000_0000);
    rdc(gpwe_pkg::OFS_DATA, 32'h0000_0002, 32'h0000_0000);
    $display("test input done");
    // Wake on rising edge of pin 2, sticky until written with one
    xfer(1'b1, gpwe_pkg::OFS_WAKE_EN, 32'h0000_0004);
    xfer(1'b1, gpwe_pkg::OFS_WAKE_GEN, 32'h0000_0001);
    pin(2, 1'b1);
    rdc(gpwe_pkg::OFS_WAKE_STS, 32'h0000_0004, 32'h0000_0004);
    chk(32'(wake_event), 32'h0000_0001);
    xfer(1'b1, gpwe_pkg::OFS_WAKE_STS, 32'h0000_0000);
    rdc(gpwe_pkg::OFS_WAKE_STS, 32'h0000_0004, 32'h0000_0004);
    xfer(1'b1, gpwe_pkg::OFS_WAKE_STS, 32'h0000_0004);
    rdc(gpwe_pkg::OFS_WAKE_STS, 32'h0000_0004, 32'h0000_0000);
    chk(32'(wake_event), 32'h0000_0000);
    // Inverted pin 3 wakes on the falling edge only
    xfer(1'b1, 8'h0C, 32'h0000_0003);
    repeat (6) @(posedge mclk);
    xfer(1'b1, gpwe_pkg::OFS_WAKE_STS, 32'h0000_0008);
    pin(3, 1'b1);
    rdc(gpwe_pkg::OFS_WAKE_STS, 32'h0000_0008, 32'h0000_0000);
    pin(3, 1'b0);
    rdc(gpwe_pkg::OFS_WAKE_STS, 32'h0000_0008, 32'h0000_0008);
    $display("test wake done");
    // Pin 9 either edge: misc status on both edges, sysint when enabled
    xfer(1'b1, gpwe_pkg::OFS_SYS_EN, 32'h0000_0200);
    pin(9, 1'b1);
    rdc(gpwe_pkg::OFS_MISC_STS, 32'h0000_0001, 32'h0000_0001);
    chk(32'(internal_sysint), 32'h0000_0001);
    xfer(1'b1, gpwe_pkg::OFS_MISC_STS, 32'h0000_0001);
    rdc(gpwe_pkg::OFS_MISC_STS, 32'h0000_0001, 32'h0000_0000);
    pin(9, 1'b0);
    rdc(gpwe_pkg::OFS_MISC_STS, 32'h0000_0001, 32'h0000_0001);
    // Either-edge selected on an output-configured pin 9: floats, and the falling edge still sets its sysint status
    xfer(1'b1, 8'h24, 32'h0000_0000);
    xfer(1'b1, gpwe_pkg::OFS_ALT_SEL, 32'h0000_0200);
    xfer(1'b1, gpwe_pkg::OFS_SYS_STS, 32'h0000_0200);
    pin(9, 1'b1);
    chk(pin_oe & 32'h0000_0200, 32'h0000_0000);
    xfer(1'b1, gpwe_pkg::OFS_SYS_STS, 32'h0000_0200);
    pin(9, 1'b0);
    rdc(gpwe_pkg::OFS_SYS_STS, 32'h0000_0200, 32'h0000_0200);
    // Fan tachometer rise lands in its own status bit
    @(posedge mclk);
    fan1 <= 1'b1;
    repeat (6) @(posedge mclk);
    rdc(gpwe_pkg::OFS_SYS_STS, 32'h4000_0000, 32'h4000_0000);
    rdc(8'hA4, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("test edges done");
    stop_test();
  end
endmodule : gpio_port_with_wake_events_tb_top
